// [hdl/pcrc_params.svh]
// offsets, field positions, reset values and fifo depths for the crc generator
`ifndef PCRC_PARAMS_SVH
`define PCRC_PARAMS_SVH
`define PCRC_OFS_CONTROL 4'h0
`define PCRC_OFS_TAPS 4'h1
`define PCRC_OFS_DATA 4'h2
`define PCRC_OFS_RESULT 4'h3
`define PCRC_BIT_IDLE_STOP 13
`define PCRC_CNT_HI 12
`define PCRC_CNT_LO 8
`define PCRC_BIT_FULL 7
`define PCRC_BIT_EMPTY 6
`define PCRC_BIT_START 4
`define PCRC_LEN_HI 3
`define PCRC_RST_CONTROL 16'h0040
`define PCRC_DEPTH_SMALL 5'h08
`define PCRC_DEPTH_LARGE 5'h10
`define PCRC_LEN_SPLIT 4'h7
`endif

// [hdl/pcrc_pkg.sv]
// types shared by the crc generator modules
package pcrc_pkg;
	typedef enum logic [1:0]
	{
		PCRC_IDLE = 2'b00,
		PCRC_SHIFT = 2'b01
	} pcrc_state_t;
	typedef logic [15:0] pcrc_word_t;
endpackage : pcrc_pkg

// [hdl/pcrc_mem_if.sv]
// interface between the crc top and its word memory
`timescale 1ns/10ps
interface pcrc_mem_if;
	logic we;
	logic [3:0] waddr;
	logic [15:0] wdata;
	logic [3:0] raddr;
	logic [15:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pcrc_mem_if

// [hdl/pcrc_mem.sv]
// word memory holding the fifo entries, registered read
`timescale 1ns/10ps
module pcrc_mem
#(
	parameter int DEPTH = 16
)
(
	input wire logic ref_clk,
	input wire logic ce,
	pcrc_mem_if.mem port
);
	logic [15:0] store [DEPTH];
	logic [15:0] next_rdata;
	logic [15:0] rdata_q;
	always_comb
	begin
		next_rdata = store[port.raddr];
		// a word written on this edge is forwarded, so a look-ahead read is never stale
		if (port.we && port.waddr == port.raddr)
			next_rdata = port.wdata;
	end
	// no reset: contents are data only
	always_ff @(posedge ref_clk)
	begin
		if (ce && port.we)
			store[port.waddr] <= port.wdata;
		if (ce)
			rdata_q <= next_rdata;
	end
	assign port.rdata = rdata_q;
endmodule : pcrc_mem

// [hdl/pcrc_lfsr.sv]
// crc engine stepping up to two data bits per clock
`timescale 1ns/10ps
module pcrc_lfsr
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic clear,
	input wire logic [1:0] step_n,
	input wire logic [1:0] bits,
	input wire logic [15:0] taps,
	input wire logic [3:0] len_m1,
	output logic [15:0] crc
);
	logic [15:0] crc_q;
	logic [15:0] next_crc;
	logic fb;
	always_comb
	begin
		next_crc = crc_q;
		fb = 1'b0;
		if (clear)
			next_crc = 16'h0000;
		else
		begin
			// msb first: upper bit of the pair goes in first
			for (int i = 0; i < 2; i++)
			begin
				if (2'(i) < step_n)
				begin
					fb = next_crc[len_m1] ^ bits[1 - i];
					next_crc = (next_crc << 1) ^ ({16{fb}} & taps);
					next_crc[0] = fb;
				end
			end
			next_crc = next_crc & ((16'h0001 << len_m1) | ((16'h0001 << len_m1) - 16'h0001));
		end
	end
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			crc_q <= 16'h0000;
		else if (ce)
			crc_q <= next_crc;
	end
	assign crc = crc_q;
endmodule : pcrc_lfsr

// [hdl/pcrc_top.sv]
// programmable crc generator with word fifo and register port
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "pcrc_params.svh"
// What this block does
// - software programs taps 15..1 and a 4-bit length field
// - constant term always fed back; top term implied at the length set by the length field
// - length field holds polynomial length minus one
// - fifo holds 8 words if length field above 7, else 16
// - byte writes accepted; word width is length field plus one
// - count increments when the word msb is written
// - shifter runs only while start bit set and count nonzero
// - count decrements after a word lsb is shifted out
// - shifter consumes two bits per clock, one for a last odd bit
// - full flag at fifo depth, empty flag at zero
// - write while full wraps count to zero, no interrupt
// - interrupt when count goes from one to zero
// - sleep freezes all state but the idle stop bit and read data, resumes where it stopped
// - idle stop bit makes idle act as sleep, no interrupt while stopped
// - control layout: count 12..8, full 7, empty 6, start 4
module pcrc_top
	import pcrc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic sleep_req,
	input wire logic idle_req,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [1:0] reg_wbe,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic crc_irq
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic idle_stop_bit, next_idle_stop_bit;
	logic shifter_start_bit, next_shifter_start_bit;
	logic [3:0] poly_length_field, next_poly_length_field;
	logic [15:1] poly_tap_register, next_poly_tap_register;
	logic [4:0] valid_word_count, next_valid_word_count;
	logic [15:0] wr_buf, next_wr_buf;
	logic [3:0] wr_ptr, next_wr_ptr;
	logic [3:0] rd_ptr, next_rd_ptr;
	logic [15:0] reg_rdata_q, next_reg_rdata;
	logic irq_q, next_irq;
	pcrc_state_t state, next_state;
	logic [15:0] shreg, next_shreg;
	logic [4:0] bits_left, next_bits_left;
	logic load_wait, next_load_wait;
	logic sleep_s1, sleep_s2, sleep_s3, idle_s1, idle_s2, idle_s3;
	logic sleep_st, idle_st, next_sleep_st, next_idle_st;
	logic run_ce;
	logic fifo_full_flag, fifo_empty_flag;
	logic [4:0] depth;
	logic [4:0] word_bits;
	logic wr_hit, msb_written, word_done, more_words;
	logic [1:0] step_n;
	logic [15:0] crc;
	logic [15:0] merged;
	pcrc_mem_if mif ();
	// ------------------------------------------------------------
	// power modes
	// ------------------------------------------------------------
	// pins cross from the power manager, three flops, act when last two agree
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
			sleep_s3 <= 1'b0;
			idle_s1 <= 1'b0;
			idle_s2 <= 1'b0;
			idle_s3 <= 1'b0;
			sleep_st <= 1'b0;
			idle_st <= 1'b0;
		end
		else if (clk_en)
		begin
			sleep_s1 <= sleep_req;
			sleep_s2 <= sleep_s1;
			sleep_s3 <= sleep_s2;
			idle_s1 <= idle_req;
			idle_s2 <= idle_s1;
			idle_s3 <= idle_s2;
			sleep_st <= next_sleep_st;
			idle_st <= next_idle_st;
		end
	end
	always_comb
	begin
		next_sleep_st = (sleep_s2 == sleep_s3) ? sleep_s3 : sleep_st;
		next_idle_st = (idle_s2 == idle_s3) ? idle_s3 : idle_st;
	end
	// freeze in sleep or stopped idle
	assign run_ce = clk_en & ~sleep_st & ~(idle_st & idle_stop_bit);
	// ------------------------------------------------------------
	// derived status
	// ------------------------------------------------------------
	// depth from length
	assign depth = (poly_length_field > `PCRC_LEN_SPLIT) ? `PCRC_DEPTH_SMALL : `PCRC_DEPTH_LARGE;
	// length field is bits minus one
	assign word_bits = {1'b0, poly_length_field} + 5'h01;
	assign fifo_full_flag = (valid_word_count == depth);
	assign fifo_empty_flag = (valid_word_count == 5'h00);
	assign wr_hit = reg_wr && (reg_addr == `PCRC_OFS_DATA);
	// count only once the lane holding the msb is written
	assign msb_written = wr_hit && (poly_length_field > 4'h7 ? reg_wbe[1] : reg_wbe[0]);
	// two bits per clock, one for a last odd bit
	assign step_n = (state == PCRC_SHIFT && !load_wait) ? ((bits_left >= 5'h02) ? 2'h2 : 2'h1) : 2'h0;
	assign word_done = (step_n != 2'h0) && (bits_left == 5'(step_n));
	assign more_words = (valid_word_count > 5'h01);
	// ------------------------------------------------------------
	// register port and fifo control
	// ------------------------------------------------------------
	always_comb
	begin
		next_idle_stop_bit = idle_stop_bit;
		next_shifter_start_bit = shifter_start_bit;
		next_poly_length_field = poly_length_field;
		next_poly_tap_register = poly_tap_register;
		next_valid_word_count = valid_word_count;
		next_wr_buf = wr_buf;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_irq = 1'b0;
		next_reg_rdata = 16'h0000;
		merged = wr_buf;
		if (reg_wbe[0])
			merged[7:0] = reg_wdata[7:0];
		if (reg_wbe[1])
			merged[15:8] = reg_wdata[15:8];
		if (reg_wr && reg_addr == `PCRC_OFS_CONTROL)
		begin
			if (reg_wbe[1])
				next_idle_stop_bit = reg_wdata[`PCRC_BIT_IDLE_STOP];
			if (reg_wbe[0])
			begin
				next_shifter_start_bit = reg_wdata[`PCRC_BIT_START];
				next_poly_length_field = reg_wdata[`PCRC_LEN_HI:0];
			end
		end
		if (reg_wr && reg_addr == `PCRC_OFS_TAPS)
		begin
			if (reg_wbe[0])
				next_poly_tap_register[7:1] = reg_wdata[7:1];
			if (reg_wbe[1])
				next_poly_tap_register[15:8] = reg_wdata[15:8];
		end
		if (wr_hit)
			next_wr_buf = merged;
		if (word_done)
			next_rd_ptr = rd_ptr + 4'h1;
		if (msb_written)
		begin
			next_wr_buf = 16'h0000;
			// overflow wraps, fifo acts empty, no interrupt
			if (fifo_full_flag)
			begin
				next_valid_word_count = 5'h00;
				next_wr_ptr = 4'h0;
				next_rd_ptr = 4'h0;
			end
			else
			begin
				next_wr_ptr = wr_ptr + 4'h1;
				next_valid_word_count = valid_word_count + (word_done ? 5'h00 : 5'h01);
			end
		end
		else if (word_done)
		begin
			next_valid_word_count = valid_word_count - 5'h01;
			next_irq = (valid_word_count == 5'h01);
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				`PCRC_OFS_CONTROL:
				begin
					next_reg_rdata[`PCRC_BIT_IDLE_STOP] = idle_stop_bit;
					next_reg_rdata[`PCRC_CNT_HI:`PCRC_CNT_LO] = valid_word_count;
					next_reg_rdata[`PCRC_BIT_FULL] = fifo_full_flag;
					next_reg_rdata[`PCRC_BIT_EMPTY] = fifo_empty_flag;
					next_reg_rdata[`PCRC_BIT_START] = shifter_start_bit;
					next_reg_rdata[`PCRC_LEN_HI:0] = poly_length_field;
				end
				`PCRC_OFS_TAPS: next_reg_rdata = {poly_tap_register, 1'b0};
				`PCRC_OFS_RESULT: next_reg_rdata = crc;
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end
	// ------------------------------------------------------------
	// serial shifter
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_shreg = shreg;
		next_bits_left = bits_left;
		next_load_wait = 1'b0;
		unique case (state)
			PCRC_IDLE:
			begin
				// start only with start bit and words present
				if (shifter_start_bit && valid_word_count != 5'h00)
				begin
					next_state = PCRC_SHIFT;
					next_load_wait = 1'b1;
				end
			end
			PCRC_SHIFT:
			begin
				if (load_wait)
				begin
					// memory read lands now; align msb to bit 15
					next_shreg = mif.rdata << (5'h10 - word_bits);
					next_bits_left = word_bits;
				end
				else
				begin
					next_shreg = shreg << step_n;
					next_bits_left = bits_left - 5'(step_n);
					// next word follows without a gap
					if (word_done && more_words)
					begin
						next_shreg = mif.rdata << (5'h10 - word_bits);
						next_bits_left = word_bits;
					end
					else if (word_done)
						next_state = PCRC_IDLE;
				end
				if (!shifter_start_bit)
					next_state = PCRC_IDLE;
				// overflow drops the word in flight
				if (msb_written && fifo_full_flag)
					next_state = PCRC_IDLE;
			end
			default: next_state = PCRC_IDLE;
		endcase
	end
	assign mif.we = msb_written && !fifo_full_flag;
	assign mif.waddr = wr_ptr;
	assign mif.wdata = merged;
	// read one word ahead while streaming so the next word is ready at word end
	assign mif.raddr = (next_state == PCRC_SHIFT && !next_load_wait) ? next_rd_ptr + 4'h1 : next_rd_ptr;
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			idle_stop_bit <= 1'b0;
			shifter_start_bit <= 1'b0;
			poly_length_field <= 4'h0;
			poly_tap_register <= 15'h0000;
			valid_word_count <= 5'h00;
			wr_buf <= 16'h0000;
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			reg_rdata_q <= 16'h0000;
			irq_q <= 1'b0;
			state <= PCRC_IDLE;
			shreg <= 16'h0000;
			bits_left <= 5'h00;
			load_wait <= 1'b0;
		end
		else if (clk_en)
		begin
			// reads and the idle stop bit stay alive so software can clear the idle stop bit
			idle_stop_bit <= next_idle_stop_bit;
			reg_rdata_q <= next_reg_rdata;
			if (run_ce)
			begin
				shifter_start_bit <= next_shifter_start_bit;
				poly_length_field <= next_poly_length_field;
				poly_tap_register <= next_poly_tap_register;
				valid_word_count <= next_valid_word_count;
				wr_buf <= next_wr_buf;
				wr_ptr <= next_wr_ptr;
				rd_ptr <= next_rd_ptr;
				state <= next_state;
				shreg <= next_shreg;
				bits_left <= next_bits_left;
				load_wait <= next_load_wait;
			end
			irq_q <= run_ce & next_irq;
		end
	end
	pcrc_mem #(.DEPTH(16)) u_mem
	(
		.ref_clk(ref_clk),
		.ce(run_ce),
		.port(mif.mem)
	);
	pcrc_lfsr u_lfsr
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(run_ce),
		.clear(1'b0),
		.step_n(step_n),
		.bits(shreg[15:14]),
		.taps({poly_tap_register, 1'b0}),
		.len_m1(poly_length_field),
		.crc(crc)
	);
	assign reg_rdata = reg_rdata_q;
	assign crc_irq = irq_q;
endmodule : pcrc_top

// [verification/pcrc_top_asserts.sv]
// port checker for the crc generator
`timescale 1ns/10ps
`include "pcrc_params.svh"
module pcrc_top_chk
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic crc_irq
);
	// ----------------------------------------
	// read sequences
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence ctrl_rd;
		reg_rd && clk_en && reg_addr == `PCRC_OFS_CONTROL;
	endsequence
	sequence taps_rd;
		reg_rd && clk_en && reg_addr == `PCRC_OFS_TAPS;
	endsequence
	sequence far_rd;
		reg_rd && clk_en && reg_addr > `PCRC_OFS_RESULT;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	// read data must not linger past its one cycle
	rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	irq_pulse_a: assert property (crc_irq |=> !crc_irq)
		else $error("interrupt longer than one cycle");
	unmapped_zero_a: assert property (far_rd |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	spare_bits_a: assert property (ctrl_rd |=> reg_rdata[15:14] == 2'h0 && !reg_rdata[5])
		else $error("unused control bits set");
	empty_flag_a: assert property (ctrl_rd |=> reg_rdata[6] == (reg_rdata[12:8] == 5'h00))
		else $error("empty flag disagrees with count");
	full_flag_a: assert property (ctrl_rd |=> reg_rdata[7] == (reg_rdata[12:8] ==
		(reg_rdata[3:0] > `PCRC_LEN_SPLIT ? `PCRC_DEPTH_SMALL : `PCRC_DEPTH_LARGE))) else $error("full flag wrong");
	count_cap_a: assert property (ctrl_rd |=> reg_rdata[12:8] <=
		(reg_rdata[3:0] > `PCRC_LEN_SPLIT ? `PCRC_DEPTH_SMALL : `PCRC_DEPTH_LARGE)) else $error("count above depth");
	tap_zero_a: assert property (taps_rd |=> !reg_rdata[0])
		else $error("constant term shows in taps");
endmodule : pcrc_top_chk
bind pcrc_top pcrc_top_chk chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_irq(crc_irq));

// [verification/programmable_crc_generator_tb.sv]
// self-checking bench for the crc generator
`timescale 1ns/10ps
`include "pcrc_params.svh"
module programmable_crc_generator_tb;
	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0] reg_wbe = 2'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep_req = 1'b0;
	logic idle_req = 1'b0;
	logic [15:0] reg_rdata;
	logic crc_irq;
	logic [15:0] rv;
	int miscompares = 0;
	int check_count = 0;
	int irq_seen = 0;
	// clock enable stays high: no rule hangs on it beyond the power-save freezes
	pcrc_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .sleep_req(sleep_req), .idle_req(idle_req),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wbe(reg_wbe), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .crc_irq(crc_irq));
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	// sampled on the falling edge, clear of the launching edge
	always @(negedge ref_clk)
		if (crc_irq === 1'b1)
			irq_seen++;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] crc16(input logic [15:0] p, input logic [15:0] d);
		logic [15:0] c;
		logic fb;
		c = 16'h0000;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb)
				c = c ^ (p | 16'h0001);
		end
		return c;
	endfunction : crc16
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wbe <= be;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(rv, e);
	endtask : rchk
	task wait_irq(output int n);
		int s;
		s = irq_seen;
		n = 0;
		while (irq_seen == s && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
	endtask : wait_irq
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rchk(`PCRC_OFS_CONTROL, `PCRC_RST_CONTROL);
		rchk(4'h9, 16'h0000);
		$display("t_reset done");
	endtask : t_reset
	task t_crc;
		int n;
		wr(`PCRC_OFS_TAPS, 16'h1021, 2'b11);
		rchk(`PCRC_OFS_TAPS, 16'h1020);
		wr(`PCRC_OFS_CONTROL, 16'h000f, 2'b11);
		wr(`PCRC_OFS_DATA, 16'h005a, 2'b01);
		rchk(`PCRC_OFS_CONTROL, 16'h004f);
		wr(`PCRC_OFS_DATA, 16'h3c00, 2'b10);
		repeat (20) @(posedge ref_clk);
		rchk(`PCRC_OFS_CONTROL, 16'h010f);
		wr(`PCRC_OFS_CONTROL, 16'h001f, 2'b11);
		wait_irq(n);
		chk(16'(n >= 8 && n <= 14), 16'h0001);
		rchk(`PCRC_OFS_CONTROL, 16'h005f);
		rchk(`PCRC_OFS_RESULT, crc16(16'h1021, 16'h3c5a));
		wr(`PCRC_OFS_CONTROL, 16'h000f, 2'b11);
		$display("t_crc done");
	endtask : t_crc
	task t_full;
		int s;
		s = irq_seen;
		for (int i = 0; i < 8; i++)
			wr(`PCRC_OFS_DATA, 16'(i * 16'h1111), 2'b11);
		rchk(`PCRC_OFS_CONTROL, 16'h088f);
		wr(`PCRC_OFS_DATA, 16'hffff, 2'b11);
		rchk(`PCRC_OFS_CONTROL, 16'h004f);
		chk(16'(irq_seen - s), 16'h0000);
		$display("t_full done");
	endtask : t_full
	task t_small;
		int n;
		wr(`PCRC_OFS_CONTROL, 16'h0007, 2'b11);
		for (int i = 0; i < 15; i++)
			wr(`PCRC_OFS_DATA, 16'h00a5, 2'b01);
		rchk(`PCRC_OFS_CONTROL, 16'h0f07);
		wr(`PCRC_OFS_DATA, 16'h00a5, 2'b01);
		rchk(`PCRC_OFS_CONTROL, 16'h1087);
		wr(`PCRC_OFS_CONTROL, 16'h0017, 2'b11);
		wait_irq(n);
		chk(16'(n >= 64 && n <= 72), 16'h0001);
		rchk(`PCRC_OFS_CONTROL, 16'h0057);
		$display("t_small done");
	endtask : t_small
	task t_power;
		int n;
		int s;
		wr(`PCRC_OFS_CONTROL, 16'h000f, 2'b11);
		wr(`PCRC_OFS_DATA, 16'hffff, 2'b11);
		wr(`PCRC_OFS_DATA, 16'h1234, 2'b11);
		s = irq_seen;
		sleep_req <= 1'b1;
		wr(`PCRC_OFS_CONTROL, 16'h001f, 2'b11);
		repeat (20) @(posedge ref_clk);
		rchk(`PCRC_OFS_CONTROL, 16'h021f);
		chk(16'(irq_seen - s), 16'h0000);
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		wait_irq(n);
		chk(16'(n >= 18 && n <= 24), 16'h0001);
		rchk(`PCRC_OFS_CONTROL, 16'h005f);
		wr(`PCRC_OFS_CONTROL, 16'h200f, 2'b11);
		wr(`PCRC_OFS_DATA, 16'hffff, 2'b11);
		idle_req <= 1'b1;
		repeat (5) @(posedge ref_clk);
		wr(`PCRC_OFS_CONTROL, 16'h201f, 2'b11);
		rchk(`PCRC_OFS_CONTROL, 16'h210f);
		wr(`PCRC_OFS_CONTROL, 16'h000f, 2'b11);
		wr(`PCRC_OFS_CONTROL, 16'h001f, 2'b11);
		wait_irq(n);
		chk(16'(n >= 8 && n <= 14), 16'h0001);
		@(posedge ref_clk);
		idle_req <= 1'b0;
		wr(`PCRC_OFS_CONTROL, 16'h000f, 2'b11);
		$display("t_power done");
	endtask : t_power
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_crc();
		t_full();
		t_small();
		t_power();
		wrap_up();
	end
	// the scenarios need well under 2000 cycles
	initial
	begin
		#100000;
		miscompares++;
		wrap_up();
	end
endmodule : programmable_crc_generator_tb
